// ==== core/dtc_pkg.sv ====
// package of register offsets, field positions and timing constants for the dual timer block
package dtc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] DTC_CTRL_FLAGS_OFS = 8'h88; // timer_ctrl_flags
  localparam logic [7:0] DTC_MODE_SEL_OFS   = 8'h89; // timer_mode_select
  localparam logic [7:0] DTC_A_LOW_OFS      = 8'h8a; // timer_a_low_byte
  localparam logic [7:0] DTC_B_LOW_OFS      = 8'h8b; // timer_b_low_byte
  localparam logic [7:0] DTC_A_HIGH_OFS     = 8'h8c; // timer_a_high_byte
  localparam logic [7:0] DTC_B_HIGH_OFS     = 8'h8d; // timer_b_high_byte
  localparam logic [7:0] DTC_CLK_CFG_OFS    = 8'h8e; // clock_config_reg

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DTC_CTRL_RST  = 8'h00;
  localparam logic [7:0] DTC_MODE_RST  = 8'h00;
  localparam logic [7:0] DTC_COUNT_RST = 8'h00;
  localparam logic [7:0] DTC_CLK_RST   = 8'h00;

  // ****************************************************************
  // timer_ctrl_flags field positions
  // ****************************************************************
  localparam int DTC_TB_OVF = 7; // timer_b_overflow_flag
  localparam int DTC_TB_RUN = 6; // timer_b_run
  localparam int DTC_TA_OVF = 5; // timer_a_overflow_flag
  localparam int DTC_TA_RUN = 4; // timer_a_run
  localparam int DTC_XB_FLG = 3; // ext_irq_b_flag
  localparam int DTC_XB_TYP = 2; // ext_irq_b_type
  localparam int DTC_XA_FLG = 1; // ext_irq_a_flag
  localparam int DTC_XA_TYP = 0; // ext_irq_a_type

  // ****************************************************************
  // timer_mode_select nibble fields (timer b upper, timer a lower)
  // ****************************************************************
  localparam int DTC_B_NIB  = 4; // base of timer b nibble
  localparam int DTC_A_NIB  = 0; // base of timer a nibble
  localparam int DTC_GATE   = 3; // gate bit within nibble
  localparam int DTC_CSEL   = 2; // counter select within nibble
  localparam int DTC_MODE_H = 1; // mode_high_bit within nibble

  // ****************************************************************
  // clock_config_reg field positions
  // ****************************************************************
  localparam int DTC_TB_CLKM = 4; // timer_b_clock_mode
  localparam int DTC_TA_CLKM = 3; // timer_a_clock_mode
  localparam logic [7:0] DTC_CLK_MASK = 8'h18; // writable bits

  // ****************************************************************
  // modes and timing
  // ****************************************************************
  typedef enum logic [1:0] {
    DTC_MODE_13,
    DTC_MODE_16,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  localparam int DTC_PRESCALE = 12; // divide ratio of slow timer clock

endpackage

// ==== core/dtc_pin_sync.sv ====
// two-flop synchroniser with falling-edge detection for one input pin
`timescale 1ns/100ps
`default_nettype none

module dtc_pin_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic meta_reg; // first stage, read only by level
  logic prev_reg; // delayed synchronised level

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  // idle-high pins reset high so no false edge at start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b1;
      level    <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      level    <= meta_reg;
      prev_reg <= level;
    end
  end

  // falling edge taken from synchronised samples only
  assign fall = prev_reg & ~level;

endmodule

`default_nettype wire

// ==== core/dtc_timer_core.sv ====
// dual timer/counter and external interrupt control with register port
`timescale 1ns/100ps
`default_nettype none

module dtc_timer_core (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  input  wire logic       timer_a_count_pin,
  input  wire logic       timer_b_count_pin,
  input  wire logic       ack_timer_a,
  input  wire logic       ack_timer_b,
  input  wire logic       ack_ext_a,
  input  wire logic       ack_ext_b,
  output logic            ext_irq_a_req,
  output logic            ext_irq_b_req,
  output logic            timer_a_irq_req,
  output logic            timer_b_irq_req
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] ctrl_reg;     // timer_ctrl_flags
  logic [7:0] mode_reg;     // timer_mode_select
  logic [7:0] clk_cfg_reg;  // clock_config_reg
  logic [7:0] a_low_reg;    // timer_a_low_byte
  logic [7:0] a_high_reg;   // timer_a_high_byte
  logic [7:0] b_low_reg;    // timer_b_low_byte
  logic [7:0] b_high_reg;   // timer_b_high_byte
  logic [3:0] div_reg;      // divide-by-twelve counter
  logic       div_tick;     // one-cycle slow clock enable

  // synchronised pins
  logic xa_lvl, xa_fall, xb_lvl, xb_fall;
  logic ca_lvl, ca_fall, cb_lvl, cb_fall;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  dtc_pin_sync u_sync_xa (.clk(clk), .sys_rst(sys_rst), .pin(ext_irq_a_pin),
                          .level(xa_lvl), .fall(xa_fall));
  dtc_pin_sync u_sync_xb (.clk(clk), .sys_rst(sys_rst), .pin(ext_irq_b_pin),
                          .level(xb_lvl), .fall(xb_fall));
  dtc_pin_sync u_sync_ca (.clk(clk), .sys_rst(sys_rst), .pin(timer_a_count_pin),
                          .level(ca_lvl), .fall(ca_fall));
  dtc_pin_sync u_sync_cb (.clk(clk), .sys_rst(sys_rst), .pin(timer_b_count_pin),
                          .level(cb_lvl), .fall(cb_fall));

  // ****************************************************************
  // prescaler
  // ****************************************************************
  localparam logic [3:0] DIV_LAST = 4'(dtc_pkg::DTC_PRESCALE - 1);

  // free-running divider producing a pulse every twelve clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_reg <= 4'h0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign div_tick = (div_reg == DIV_LAST);

  // ****************************************************************
  // count enables
  // ****************************************************************
  // pick the count source of one timer
  function automatic logic count_src(input logic csel, input logic clkm,
                                     input logic tick, input logic fall);
    if (csel) begin
      count_src = fall; // external pin falling edge
    end else if (clkm) begin
      count_src = 1'b1; // undivided system clock
    end else begin
      count_src = tick; // system clock over twelve
    end
  endfunction

  logic [3:0] a_nib, b_nib;
  logic       a_gate_ok, b_gate_ok;
  logic       a_inc, b_inc, a_hi_inc;
  logic [1:0] a_mode, b_mode;

  assign a_nib     = mode_reg[dtc_pkg::DTC_A_NIB +: 4];
  assign b_nib     = mode_reg[dtc_pkg::DTC_B_NIB +: 4];
  assign a_mode    = a_nib[dtc_pkg::DTC_MODE_H -: 2];
  assign b_mode    = b_nib[dtc_pkg::DTC_MODE_H -: 2];
  assign a_gate_ok = ~a_nib[dtc_pkg::DTC_GATE] | xa_lvl;
  assign b_gate_ok = ~b_nib[dtc_pkg::DTC_GATE] | xb_lvl;

  // run bit zero stops the timer and the count stays put; the split high byte of timer a runs on timer b run instead
  assign a_inc = ctrl_reg[dtc_pkg::DTC_TA_RUN] & a_gate_ok
               & count_src(a_nib[dtc_pkg::DTC_CSEL], clk_cfg_reg[dtc_pkg::DTC_TA_CLKM],
                           div_tick, ca_fall);
  assign b_inc = ctrl_reg[dtc_pkg::DTC_TB_RUN] & b_gate_ok
               & (b_mode != 2'b11) // mode three halts timer b
               & count_src(b_nib[dtc_pkg::DTC_CSEL], clk_cfg_reg[dtc_pkg::DTC_TB_CLKM],
                           div_tick, cb_fall);
  // split high byte: internal clock only, started by timer b run
  assign a_hi_inc = ctrl_reg[dtc_pkg::DTC_TB_RUN]
                  & (clk_cfg_reg[dtc_pkg::DTC_TA_CLKM] | div_tick);

  // ****************************************************************
  // counter step function
  // ****************************************************************
  // returns next {high, low} and overflow for one timer step
  function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      2'b00: begin
        // five-bit prescaler carries into high byte
        if (lo[4:0] == 5'h1f) begin
          r = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      2'b01: begin
        r = {1'b0, hi, lo} + 17'h00001; // 16-bit count
      end
      default: begin
        // 8-bit with reload from high byte; split low byte wraps to zero instead
        if (lo == 8'hff) begin
          r = {1'b1, hi, (mode == 2'b10) ? hi : 8'h00};
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
    endcase
    step = r;
  endfunction

  logic [16:0] a_step, b_step;
  logic        a_ovf, b_ovf, a_hi_ovf;

  assign a_step   = step(a_mode, a_low_reg, a_high_reg);
  assign b_step   = step(b_mode, b_low_reg, b_high_reg);
  assign a_ovf    = a_inc & a_step[16];
  assign b_ovf    = b_inc & b_step[16];
  assign a_hi_ovf = (a_mode == 2'b11) & a_hi_inc & (a_high_reg == 8'hff);

  // register write decode
  logic wr_ctrl, wr_mode, wr_clk, wr_al, wr_ah, wr_bl, wr_bh;

  assign wr_ctrl = wr_stb & (addr == dtc_pkg::DTC_CTRL_FLAGS_OFS);
  assign wr_mode = wr_stb & (addr == dtc_pkg::DTC_MODE_SEL_OFS);
  assign wr_clk  = wr_stb & (addr == dtc_pkg::DTC_CLK_CFG_OFS);
  assign wr_al   = wr_stb & (addr == dtc_pkg::DTC_A_LOW_OFS);
  assign wr_ah   = wr_stb & (addr == dtc_pkg::DTC_A_HIGH_OFS);
  assign wr_bl   = wr_stb & (addr == dtc_pkg::DTC_B_LOW_OFS);
  assign wr_bh   = wr_stb & (addr == dtc_pkg::DTC_B_HIGH_OFS);

  // ****************************************************************
  // timer a count bytes
  // ****************************************************************
  // software write wins over a count in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_low_reg  <= dtc_pkg::DTC_COUNT_RST;
      a_high_reg <= dtc_pkg::DTC_COUNT_RST;
    end else begin
      if (wr_al) begin
        a_low_reg <= wdata;
      end else if (a_inc) begin
        a_low_reg <= a_step[7:0];
      end
      if (wr_ah) begin
        a_high_reg <= wdata;
      end else if (a_mode == 2'b11) begin
        if (a_hi_inc) begin
          a_high_reg <= a_high_reg + 8'h01; // separate 8-bit timer
        end
      end else if (a_inc) begin
        a_high_reg <= a_step[15:8];
      end
    end
  end

  // ****************************************************************
  // timer b count bytes
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_low_reg  <= dtc_pkg::DTC_COUNT_RST;
      b_high_reg <= dtc_pkg::DTC_COUNT_RST;
    end else begin
      if (wr_bl) begin
        b_low_reg <= wdata;
      end else if (b_inc) begin
        b_low_reg <= b_step[7:0];
      end
      if (wr_bh) begin
        b_high_reg <= wdata;
      end else if (b_inc) begin
        b_high_reg <= b_step[15:8];
      end
    end
  end

  // ****************************************************************
  // mode and clock configuration
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg    <= dtc_pkg::DTC_MODE_RST;
      clk_cfg_reg <= dtc_pkg::DTC_CLK_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata;
      end
      if (wr_clk) begin
        clk_cfg_reg <= wdata & dtc_pkg::DTC_CLK_MASK;
      end
    end
  end

  // ****************************************************************
  // control and flag register
  // ****************************************************************
  // next value of an edge flag: hardware set beats any clear
  function automatic logic edge_flag(input logic cur, input logic wr, input logic wv,
                                     input logic ack, input logic set);
    logic n;
    n = cur;
    if (wr) begin
      n = wv;
    end
    if (ack) begin
      n = 1'b0;
    end
    if (set) begin
      n = 1'b1;
    end
    edge_flag = n;
  endfunction

  logic xa_type, xb_type;

  assign xa_type = ctrl_reg[dtc_pkg::DTC_XA_TYP];
  assign xb_type = ctrl_reg[dtc_pkg::DTC_XB_TYP];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= dtc_pkg::DTC_CTRL_RST;
    end else begin
      // run and type bits are plain software bits
      if (wr_ctrl) begin
        ctrl_reg[dtc_pkg::DTC_TB_RUN] <= wdata[dtc_pkg::DTC_TB_RUN];
        ctrl_reg[dtc_pkg::DTC_TA_RUN] <= wdata[dtc_pkg::DTC_TA_RUN];
        ctrl_reg[dtc_pkg::DTC_XB_TYP] <= wdata[dtc_pkg::DTC_XB_TYP];
        ctrl_reg[dtc_pkg::DTC_XA_TYP] <= wdata[dtc_pkg::DTC_XA_TYP];
      end
      ctrl_reg[dtc_pkg::DTC_TB_OVF] <= edge_flag(ctrl_reg[dtc_pkg::DTC_TB_OVF], wr_ctrl,
        wdata[dtc_pkg::DTC_TB_OVF], ack_timer_b, b_ovf | a_hi_ovf);
      ctrl_reg[dtc_pkg::DTC_TA_OVF] <= edge_flag(ctrl_reg[dtc_pkg::DTC_TA_OVF], wr_ctrl,
        wdata[dtc_pkg::DTC_TA_OVF], ack_timer_a, a_ovf);
      // level mode: flag follows inverted pin, writes ignored
      if (xb_type) begin
        ctrl_reg[dtc_pkg::DTC_XB_FLG] <= edge_flag(ctrl_reg[dtc_pkg::DTC_XB_FLG], wr_ctrl,
          wdata[dtc_pkg::DTC_XB_FLG], ack_ext_b, xb_fall);
      end else begin
        ctrl_reg[dtc_pkg::DTC_XB_FLG] <= ~xb_lvl;
      end
      if (xa_type) begin
        ctrl_reg[dtc_pkg::DTC_XA_FLG] <= edge_flag(ctrl_reg[dtc_pkg::DTC_XA_FLG], wr_ctrl,
          wdata[dtc_pkg::DTC_XA_FLG], ack_ext_a, xa_fall);
      end else begin
        ctrl_reg[dtc_pkg::DTC_XA_FLG] <= ~xa_lvl;
      end
    end
  end

  // ****************************************************************
  // request outputs and read port
  // ****************************************************************
  // flags copied to registered request outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_a_irq_req <= 1'b0;
      timer_b_irq_req <= 1'b0;
      ext_irq_a_req   <= 1'b0;
      ext_irq_b_req   <= 1'b0;
    end else begin
      timer_a_irq_req <= ctrl_reg[dtc_pkg::DTC_TA_OVF];
      timer_b_irq_req <= ctrl_reg[dtc_pkg::DTC_TB_OVF];
      ext_irq_a_req   <= ctrl_reg[dtc_pkg::DTC_XA_FLG];
      ext_irq_b_req   <= ctrl_reg[dtc_pkg::DTC_XB_FLG];
    end
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (!rd_stb) begin
      rdata <= 8'h00;
    end else if (addr == dtc_pkg::DTC_CTRL_FLAGS_OFS) begin
      rdata <= ctrl_reg;
    end else if (addr == dtc_pkg::DTC_MODE_SEL_OFS) begin
      rdata <= mode_reg;
    end else if (addr == dtc_pkg::DTC_A_LOW_OFS) begin
      rdata <= a_low_reg;
    end else if (addr == dtc_pkg::DTC_B_LOW_OFS) begin
      rdata <= b_low_reg;
    end else if (addr == dtc_pkg::DTC_A_HIGH_OFS) begin
      rdata <= a_high_reg;
    end else if (addr == dtc_pkg::DTC_B_HIGH_OFS) begin
      rdata <= b_high_reg;
    end else if (addr == dtc_pkg::DTC_CLK_CFG_OFS) begin
      rdata <= clk_cfg_reg;
    end else begin
      rdata <= 8'h00; // unmapped address reads zero
    end
  end

endmodule

`default_nettype wire

// ==== tb/dtc_timer_core_sva.sv ====
// assertion checker for the dual timer block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_core_sva (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic [7:0] rdata,
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  input  wire logic       ack_ext_b,
  input  wire logic       ext_irq_a_req,
  input  wire logic       ext_irq_b_req,
  input  wire logic       timer_a_irq_req,
  input  wire logic       timer_b_irq_req
);
  // ****************************************************************
  // shadow of the software-only control bits
  // ****************************************************************
  localparam logic [7:0] CTL = dtc_pkg::DTC_CTRL_FLAGS_OFS; // control offset
  logic ctl_wr;                                 // write to control register
  logic clr_b;                                  // edge flag b cleared by ack or write
  logic set_a, set_b;                           // software sets an overflow flag
  logic type_a_reg, type_b_reg, run_a_reg, run_b_reg; // shadowed bits
  assign ctl_wr = wr_stb && addr == CTL;
  assign clr_b  = ack_ext_b || (ctl_wr && !wdata[3]);
  assign set_a  = ctl_wr && wdata[5];
  assign set_b  = ctl_wr && wdata[7];
  // track run and type bits as software writes them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {run_b_reg, run_a_reg, type_b_reg, type_a_reg} <= 4'h0;
    end else if (ctl_wr) begin
      {run_b_reg, run_a_reg, type_b_reg, type_a_reg} <= {wdata[6], wdata[4], wdata[2], wdata[0]};
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_read_slot_only: assert property (rdata != 8'h00 |-> $past(rd_stb))
    else $error("read data outside a read slot");
  a_mode_readback: assert property (
    wr_stb && addr == 8'h89 ##1 rd_stb && addr == 8'h89 |=> rdata == $past(wdata, 2))
    else $error("mode register readback differs");
  a_unmapped_zero: assert property (
    rd_stb && (addr < 8'h88 || addr > 8'h8e) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_level_a_low: assert property (
    (!ext_irq_a_pin && !type_a_reg)[*6] |-> ext_irq_a_req)
    else $error("level flag a not following low pin");
  a_level_b_high: assert property (
    (ext_irq_b_pin && !type_b_reg)[*6] |-> !ext_irq_b_req)
    else $error("level flag b set with pin high");
  a_edge_a_sets: assert property (
    type_a_reg && $fell(ext_irq_a_pin) |-> ##[2:6] ext_irq_a_req)
    else $error("edge flag a missed a falling edge");
  a_edge_b_holds: assert property (
    $fell(ext_irq_b_req) && type_b_reg && $past(type_b_reg, 2) |-> $past(clr_b, 2))
    else $error("edge flag b dropped without clear");
  a_ovf_a_cause: assert property (
    $rose(timer_a_irq_req) |-> $past(run_a_reg, 2) || $past(set_a, 2))
    else $error("timer a flag set while stopped");
  a_ovf_b_cause: assert property (
    $rose(timer_b_irq_req) |-> $past(run_b_reg, 2) || $past(set_b, 2))
    else $error("timer b flag set while stopped");
  // main scenarios reached
  c_read: cover property (rd_stb ##1 rdata != 8'h00);
  c_ovf_a: cover property ($rose(timer_a_irq_req));
  c_ovf_b: cover property ($rose(timer_b_irq_req));
  c_edge_b: cover property ($rose(ext_irq_b_req) && type_b_reg);
endmodule
bind dtc_timer_core dtc_timer_core_sva u_sva (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .ext_irq_a_pin, .ext_irq_b_pin, .ack_ext_b, .ext_irq_a_req, .ext_irq_b_req,
  .timer_a_irq_req, .timer_b_irq_req);
`default_nettype wire

// ==== tb/dtc_pin_model.sv ====
// model of the far-side pins: two interrupt inputs and two count inputs
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
  input  wire logic clk,
  output logic      ext_irq_a_pin,
  output logic      ext_irq_b_pin,
  output logic      timer_a_count_pin,
  output logic      timer_b_count_pin
);
  // ****************************************************************
  // pin levels: 0 irq a, 1 irq b, 2 count a, 3 count b; pulled up idle
  // ****************************************************************
  logic [3:0] lvl = 4'hf; // idle high like a pulled-up pin
  assign {timer_b_count_pin, timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin} = lvl;
  // drive one pin and let the synchronisers settle
  task automatic set_pin(input int i, input logic v);
    lvl[i] <= v;
    repeat (4) @(posedge clk);
  endtask
  // n falling edges, low and high for hold cycles each (short hold is prompt)
  task automatic pulses(input int i, input int n, input int hold);
    repeat (n) begin
      lvl[i] <= 1'b0;
      repeat (hold) @(posedge clk);
      lvl[i] <= 1'b1;
      repeat (hold) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/test_dual_timer_ext_irq_control.sv ====
// self-checking bench for the dual timer and external interrupt block
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_ext_irq_control;
  typedef struct {int t; logic [1:0] m; logic [7:0] tl, th; int n; logic [7:0] etl; logic ov;} dtc_case_t;
  logic        clk, sys_rst, wr_stb, rd_stb, rd_d; // clock, reset, bus strobes
  logic [7:0]  addr, wdata, rdata;                  // register port
  logic [3:0]  ack;                                 // service-routine entry pulses
  wire  [3:0]  pin, req;                            // far-side pins, requests
  logic [7:0]  exp_q[$];                            // expected read data
  int          failures, comparisons, cycles;       // counters
  logic [31:0] seed;                                // random state
  dtc_case_t   cases [8];                           // timer mode table
  dtc_timer_core u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_irq_a_pin(pin[0]),
    .ext_irq_b_pin(pin[1]), .timer_a_count_pin(pin[2]), .timer_b_count_pin(pin[3]),
    .ack_ext_a(ack[0]), .ack_ext_b(ack[1]), .ack_timer_a(ack[2]), .ack_timer_b(ack[3]),
    .ext_irq_a_req(req[0]), .ext_irq_b_req(req[1]), .timer_a_irq_req(req[2]),
    .timer_b_irq_req(req[3]));
  dtc_pin_model u_pins (.clk(clk), .ext_irq_a_pin(pin[0]), .ext_irq_b_pin(pin[1]),
    .timer_a_count_pin(pin[2]), .timer_b_count_pin(pin[3]));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // bus write, strobe left up so transfers may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge clk);
  endtask
  // bus read, expected value noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    ack <= 4'h0;
    repeat (n) @(posedge clk);
  endtask
  // one-cycle service-routine entry pulse
  task automatic ackp(input int i);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    ack[i] <= 1'b1;
    @(posedge clk);
    idle(4);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // count pulses on one timer, then check ack, software set and stopped hold
  task automatic run_case(input dtc_case_t c);
    logic [7:0] lo, run;
    lo = 8'h8a + 8'(c.t);
    run = c.t ? 8'h40 : 8'h10;
    wr(8'h88, 8'h00);
    wr(8'h89, 8'({2'b01, c.m}) << (4 * c.t));
    wr(lo, c.tl);
    wr(lo + 8'h02, c.th);
    wr(8'h88, run);
    idle(1);
    u_pins.pulses(2 + c.t, c.n, 3 + 4 * c.t);
    idle(6);
    rd(lo, c.etl);
    idle(1);
    check(8'(req[2 + c.t]), 8'(c.ov), "overflow request");
    ackp(2 + c.t);
    check(8'(req[2 + c.t]), 8'h00, "request after ack");
    wr(8'h88, run | (run << 1));
    idle(3);
    check(8'(req[2 + c.t]), 8'h01, "software set flag");
    wr(8'h88, 8'h00);
    idle(1);
    u_pins.pulses(2 + c.t, 2, 3);
    idle(6);
    rd(lo, c.etl);
    idle(1);
    check(8'(req[2 + c.t]), 8'h00, "software clear flag");
  endtask
  // ****************************************************************
  // clock, read monitor and hang limit
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    rd_d <= rd_stb;
    cycles <= cycles + 1;
    if (rd_d) check(rdata, exp_q.pop_front(), "read data");
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {sys_rst, wr_stb, rd_stb, rd_d} = 4'h8;
    addr = 8'h00;
    wdata = 8'h00;
    ack = 4'h0;
    {failures, comparisons, cycles} = '0;
    seed = 32'h7cdf0b51;
    cases = '{'{0, 2'b01, 8'hfd, 8'hff, 3, 8'h00, 1'b1}, '{1, 2'b01, 8'hfd, 8'hff, 3, 8'h00, 1'b1},
      '{0, 2'b00, 8'hfe, 8'hff, 2, 8'he0, 1'b1}, '{1, 2'b00, 8'h1e, 8'h00, 2, 8'h00, 1'b0},
      '{0, 2'b10, 8'hfe, 8'h80, 2, 8'h80, 1'b1}, '{1, 2'b10, 8'hfe, 8'h80, 2, 8'h80, 1'b1},
      '{1, 2'b11, 8'h05, 8'h00, 3, 8'h05, 1'b0}, '{0, 2'b11, 8'hff, 8'h00, 1, 8'h00, 1'b1}};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 8'h88; a <= 8'h8f; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      wr(8'h89 + 8'(i), seed[7:0]);
      rd(8'h89 + 8'(i), i == 6 ? 8'h00 : i == 5 ? seed[7:0] & 8'h18 : seed[7:0]);
    end
    idle(2);
    $display("test register access done");
    foreach (cases[k]) run_case(cases[k]);
    $display("test timer modes done");
    for (int t = 0; t < 2; t++) begin
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h0d << (4 * t));
      wr(8'h8a + 8'(t), 8'h00);
      wr(8'h88, t ? 8'h40 : 8'h10);
      idle(1);
      u_pins.set_pin(t, 1'b0);
      u_pins.pulses(2 + t, 2, 3);
      u_pins.set_pin(t, 1'b1);
      u_pins.pulses(2 + t, 3, 3);
      idle(6);
      rd(8'h8a + 8'(t), 8'h03);
      idle(1);
    end
    $display("test gating done");
    for (int t = 0; t < 2; t++) begin
      wr(8'h88, t ? 8'h04 : 8'h01);
      idle(1);
      u_pins.set_pin(t, 1'b0);
      idle(4);
      check(8'(req[t]), 8'h01, "edge flag set");
      rd(8'h88, t ? 8'h0c : 8'h03);
      idle(1);
      u_pins.set_pin(t, 1'b1);
      idle(4);
      check(8'(req[t]), 8'h01, "edge flag held");
      ackp(t);
      check(8'(req[t]), 8'h00, "edge flag after ack");
      wr(8'h88, 8'h00);
      idle(1);
      u_pins.set_pin(t, 1'b0);
      idle(4);
      check(8'(req[t]), 8'h01, "level flag follows pin");
      wr(8'h88, 8'h00);
      idle(4);
      check(8'(req[t]), 8'h01, "level flag ignores write");
      u_pins.set_pin(t, 1'b1);
      idle(6);
      check(8'(req[t]), 8'h00, "level flag released");
    end
    $display("test external flags done");
    // internal clock, both clock modes: split timer a, 24-cycle run window
    for (int m = 0; m < 2; m++) begin
      wr(8'h8e, m ? 8'h18 : 8'h00);
      wr(8'h89, 8'h03);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'hfc);
      wr(8'h88, 8'h50);
      idle(23);
      check(8'(req[3]), 8'(m), "split high overflow");
      wr(8'h88, 8'h00);
      idle(2);
      rd(8'h8a, m ? 8'h18 : 8'h02);
      rd(8'h8c, m ? 8'h14 : 8'hfe);
      idle(2);
    end
    $display("test internal clock done");
    give_verdict();
  end
endmodule
`default_nettype wire
